/* File: src/blinker_defs.svh */
// Constants for the four-channel interval LED blinker: widths, offsets, reset values, counts.
// Assumes it is included by bare name from files under src/.
`ifndef BLINKER_DEFS_SVH
`define BLINKER_DEFS_SVH

`define NUM_CH        4
`define CMP_W         8
`define HITS_W        11
`define TOGGLE_COUNT  11'h7D0
`define PRESC_W       7
`define SET_W         3
`define CH_STEP       3'h2
`define ADDR_W        4
`define DATA_W        16
`define STAT_W        5
`define SW_BIT        4

`define OFS_CMP0      4'h0
`define OFS_CMP1      4'h1
`define OFS_CMP2      4'h2
`define OFS_CMP3      4'h3
`define OFS_STATUS    4'h4
`define OFS_MASK      4'h5
`define OFS_SETTING   4'h6
`define OFS_PRESSES   4'h7
`define OFS_LEDS      4'h8

`define CMP0_RST      8'h3F
`define CMP1_RST      8'h7F
`define CMP2_RST      8'hBF
`define CMP3_RST      8'hFF
`define MASK_RST      5'h1F
`define SYNC_RST      3'h7

`endif

/* File: src/blinker_pkg.sv */
// Types shared by the blinker top module and its channel module.
// Assumes blinker_defs.svh is reachable on the include path.
`default_nettype none
`include "blinker_defs.svh"

package blinker_pkg;

    typedef logic [`NUM_CH-1:0][`CMP_W-1:0] cmp_arr_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [`CMP_W-1:0]  cnt;
        logic [`HITS_W-1:0] hits;
        logic               led;
        logic               match;
    } chan_state_t;

    typedef struct packed {
        logic [2:0]          sw_sync;
        logic [`PRESC_W-1:0] presc;
        logic [`SET_W-1:0]   setting;
        logic [`DATA_W-1:0]  presses;
        cmp_arr_t            cmp;
        logic [`STAT_W-1:0]  status;
        logic [`STAT_W-1:0]  mask;
        logic                sw_pulse;
        logic [`DATA_W-1:0]  rdata;
    } top_state_t;

endpackage

`default_nettype wire

/* File: src/interval_channel.sv */
// One interval channel: 8-bit counter with compare, match counter and LED toggle.
// Assumes tick_in is a one-cycle enable from the same clock and compare_in is registered.
`timescale 1ns/1ns
`default_nettype none
`include "blinker_defs.svh"

module interval_channel #(
    parameter logic [`HITS_W-1:0] LIMIT = `TOGGLE_COUNT
) (
    input  wire logic               clk_in,     // block clock
    input  wire logic               rst_in,     // synchronous reset, high
    input  wire logic               ce_in,      // clock enable, freezes state when low
    input  wire logic               tick_in,    // divided count enable
    input  wire logic [`CMP_W-1:0]  compare_in, // compare value
    output logic                    match_out,  // one-cycle compare match pulse
    output logic                    led_out,    // LED level
    output logic [`CMP_W-1:0]       count_out   // current counter value
);

    blinker_pkg::chan_state_t r;
    blinker_pkg::chan_state_t nxt;

    always_comb begin
        nxt       = r;
        nxt.match = 1'b0;
        if (tick_in) begin
            if (r.cnt == compare_in) begin
                nxt.cnt   = '0;
                nxt.match = 1'b1;
                if (r.hits == LIMIT - 1'b1) begin
                    nxt.hits = '0;
                    nxt.led  = ~r.led;
                end else begin
                    nxt.hits = r.hits + 1'b1;
                end
            end else begin
                nxt.cnt = r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
        end else if (ce_in) begin
            r <= nxt;
        end
    end

    assign match_out = r.match;
    assign led_out   = r.led;
    assign count_out = r.cnt;

endmodule // interval_channel

`default_nettype wire

/* File: src/quad_interval_led_blinker.sv */
// Four interval timer channels that blink four LEDs, with a switch rotating the blink rates.
// Assumes one 10 MHz clock, a synchronous active-high reset and an idle-high push switch pin.
//
// Overview of operation
// - Each of four channels runs an independent 8-bit counter.
// - Each channel has a compare value; resets are 3F, 7F, BF, FF hex.
// - A compare match raises the shared timer interrupt and sets that channel's flag.
// - Matches are counted per channel; the 2000th match inverts that channel's LED.
// - Four LED outputs, one per channel, channel 0 through 3.
// - Channel clock is source divided by 1..128; first setting uses 1, 4, 16, 64.
// - Eight settings advance one per press and wrap; each step doubles every ratio except 128, which wraps to 1.
// - The switch is detected on its falling edge only, one event per edge.
// - Each switch event increments the press count and applies the next ratio setting.
`timescale 1ns/1ns
`default_nettype none
`include "blinker_defs.svh"

module quad_interval_led_blinker #(
    parameter logic [`HITS_W-1:0] TOGGLE_LIMIT = `TOGGLE_COUNT
) (
    input  wire logic               CLK_IN,                 // 10 MHz block clock
    input  wire logic               RST_IN,                 // synchronous reset, active high
    input  wire logic               CE_IN,                  // clock enable, low freezes all state
    input  wire logic               PUSH_SWITCH_INPUT_IN,   // switch pin, pressed is low
    input  wire logic [`ADDR_W-1:0] ADDR_IN,                // register address
    input  wire logic [`DATA_W-1:0] WDATA_IN,               // register write data
    input  wire logic               WR_IN,                  // write strobe
    input  wire logic               RD_IN,                  // read strobe
    output logic      [`DATA_W-1:0] RDATA_OUT,              // read data, cycle after read strobe
    output logic      [`NUM_CH-1:0] LED_OUT,                // LED levels, bit n is channel n
    output logic      [`NUM_CH-1:0] MATCH_FLAG_OUT,         // sticky match flags, channels 0 to 3
    output logic                    TIMER_SHARED_IRQ_OUT,   // level, any unmasked match flag set
    output logic                    SWITCH_EDGE_IRQ_OUT,    // one-cycle pulse per falling edge
    output logic                    IRQ_OUT                 // level, any unmasked status bit set
);

    blinker_pkg::top_state_t r;
    blinker_pkg::top_state_t nxt;
    blinker_pkg::bus_req_t   req;

    logic [`NUM_CH-1:0]             ch_match;
    logic [`NUM_CH-1:0]             ch_led;
    logic [`NUM_CH-1:0]             ch_tick;
    logic [`NUM_CH-1:0][`SET_W-1:0] ch_exp;
    logic [`NUM_CH-1:0][`PRESC_W-1:0] ch_div_mask;
    logic                           sw_fall;
    logic [`STAT_W-1:0]             set_bits;
    logic [`STAT_W-1:0]             clr_bits;

    assign req.wr    = WR_IN;
    assign req.rd    = RD_IN;
    assign req.addr  = ADDR_IN;
    assign req.wdata = WDATA_IN;

    // The third stage is only an edge memory; the first stage feeds nothing but the second.
    assign sw_fall = r.sw_sync[2] & ~r.sw_sync[1];

    // Ratio exponent of channel n is the setting plus two per channel, wrapping
    // modulo eight, so 128 wraps to 1 as the setting advances.
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_CH; gi++) begin : g_ch
            assign ch_exp[gi] = r.setting + `SET_W'(gi) * `CH_STEP;
            assign ch_div_mask[gi] = `PRESC_W'((8'h01 << ch_exp[gi]) - 8'h01);
            // A shared free-running prescaler keeps all channels phase related;
            // the trade is that a ratio change takes effect mid-period.
            assign ch_tick[gi] = ((r.presc & ch_div_mask[gi]) == ch_div_mask[gi]);

            interval_channel #(
                .LIMIT      (TOGGLE_LIMIT)
            ) u_chan (
                .clk_in     (CLK_IN),
                .rst_in     (RST_IN),
                .ce_in      (CE_IN),
                .tick_in    (ch_tick[gi]),
                .compare_in (r.cmp[gi]),
                .match_out  (ch_match[gi]),
                .led_out    (ch_led[gi]),
                .count_out  ()
            );
        end
    endgenerate

    assign set_bits = {sw_fall, ch_match};

    always_comb begin
        clr_bits = '0;
        if (req.wr && req.addr == `OFS_STATUS) begin
            clr_bits = req.wdata[`STAT_W-1:0];
        end
    end

    always_comb begin
        nxt = r;

        // Switch synchroniser and falling-edge memory.
        nxt.sw_sync = {r.sw_sync[1:0], PUSH_SWITCH_INPUT_IN};

        nxt.presc = r.presc + 1'b1;

        nxt.sw_pulse = sw_fall;
        if (sw_fall) begin
            nxt.setting = r.setting + 1'b1;
            nxt.presses = r.presses + 1'b1;
        end

        // A flag set in the same cycle as its clear stays set.
        nxt.status = (r.status & ~clr_bits) | set_bits;

        if (req.wr) begin
            case (req.addr)
                `OFS_CMP0: begin
                    nxt.cmp[0] = req.wdata[`CMP_W-1:0];
                end
                `OFS_CMP1: begin
                    nxt.cmp[1] = req.wdata[`CMP_W-1:0];
                end
                `OFS_CMP2: begin
                    nxt.cmp[2] = req.wdata[`CMP_W-1:0];
                end
                `OFS_CMP3: begin
                    nxt.cmp[3] = req.wdata[`CMP_W-1:0];
                end
                `OFS_MASK: begin
                    nxt.mask = req.wdata[`STAT_W-1:0];
                end
                default: begin
                    nxt.mask = r.mask;
                end
            endcase
        end

        // Read data stand only in the cycle after the strobe; otherwise zero.
        nxt.rdata = '0;
        if (req.rd) begin
            case (req.addr)
                `OFS_CMP0: begin
                    nxt.rdata = `DATA_W'(r.cmp[0]);
                end
                `OFS_CMP1: begin
                    nxt.rdata = `DATA_W'(r.cmp[1]);
                end
                `OFS_CMP2: begin
                    nxt.rdata = `DATA_W'(r.cmp[2]);
                end
                `OFS_CMP3: begin
                    nxt.rdata = `DATA_W'(r.cmp[3]);
                end
                `OFS_STATUS: begin
                    nxt.rdata = `DATA_W'(r.status);
                end
                `OFS_MASK: begin
                    nxt.rdata = `DATA_W'(r.mask);
                end
                `OFS_SETTING: begin
                    nxt.rdata = `DATA_W'(r.setting);
                end
                `OFS_PRESSES: begin
                    nxt.rdata = r.presses;
                end
                `OFS_LEDS: begin
                    nxt.rdata = `DATA_W'(ch_led);
                end
                default: begin
                    nxt.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            r         <= '0;
            // Idle-high reset of the synchroniser avoids a false edge after release.
            r.sw_sync <= `SYNC_RST;
            r.cmp[0]  <= `CMP0_RST;
            r.cmp[1]  <= `CMP1_RST;
            r.cmp[2]  <= `CMP2_RST;
            r.cmp[3]  <= `CMP3_RST;
            r.mask    <= `MASK_RST;
        end else if (CE_IN) begin
            r <= nxt;
        end
    end

    assign RDATA_OUT            = r.rdata;
    assign LED_OUT              = ch_led;
    assign MATCH_FLAG_OUT       = r.status[`NUM_CH-1:0];
    assign TIMER_SHARED_IRQ_OUT = |(r.status[`NUM_CH-1:0] & r.mask[`NUM_CH-1:0]);
    assign SWITCH_EDGE_IRQ_OUT  = r.sw_pulse;
    assign IRQ_OUT              = |(r.status & r.mask);

endmodule // quad_interval_led_blinker

`default_nettype wire

/* File: verification/blinker_asserts.sv */
// Checker on the blinker top ports: read port, interrupts, switch edge and LEDs.
// Assumes it is bound to the top module and that the switch mask bit stays set.
`timescale 1ns/1ns
`default_nettype none
`include "blinker_defs.svh"
module blinker_asserts #(
    parameter logic [`HITS_W-1:0] TOGGLE_LIMIT = `TOGGLE_COUNT
) (
    input wire logic               CLK_IN,               // clock
    input wire logic               RST_IN,               // reset
    input wire logic               CE_IN,                // enable
    input wire logic               PUSH_SWITCH_INPUT_IN, // pin
    input wire logic [`ADDR_W-1:0] ADDR_IN,              // address
    input wire logic               WR_IN,                // write
    input wire logic               RD_IN,                // read
    input wire logic [`DATA_W-1:0] RDATA_OUT,            // data
    input wire logic [`NUM_CH-1:0] LED_OUT,              // LEDs
    input wire logic [`NUM_CH-1:0] MATCH_FLAG_OUT,       // flags
    input wire logic               TIMER_SHARED_IRQ_OUT, // timer irq
    input wire logic               SWITCH_EDGE_IRQ_OUT,  // edge pulse
    input wire logic               IRQ_OUT               // irq
);
    default clocking cb @(posedge CLK_IN); endclocking
    // A frozen block may miss pin edges and hold its outputs, so nothing is checked then.
    default disable iff (RST_IN || !CE_IN);
    rdata_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 16'h0000)
        else $error("read data not idle");
    flag_irq_a: assert property (TIMER_SHARED_IRQ_OUT |-> |MATCH_FLAG_OUT)
        else $error("timer irq without flag");
    irq_merge_a: assert property (TIMER_SHARED_IRQ_OUT |-> IRQ_OUT)
        else $error("timer irq not merged");
    // Flags are sticky, so only a status write may clear one.
    flag_clear_a: assert property (|($past(MATCH_FLAG_OUT) & ~MATCH_FLAG_OUT)
        |-> $past(WR_IN) && $past(ADDR_IN) == `OFS_STATUS) else $error("flag lost");
    edge_seen_a: assert property ($fell(PUSH_SWITCH_INPUT_IN) |-> ##[2:4] SWITCH_EDGE_IRQ_OUT)
        else $error("fall not seen");
    edge_pulse_a: assert property (SWITCH_EDGE_IRQ_OUT |=> !SWITCH_EDGE_IRQ_OUT)
        else $error("edge pulse too long");
    fall_only_a: assert property (SWITCH_EDGE_IRQ_OUT |-> !$past(PUSH_SWITCH_INPUT_IN, 2))
        else $error("edge pulse on rise");
    switch_irq_a: assert property (SWITCH_EDGE_IRQ_OUT |-> ##[0:1] IRQ_OUT)
        else $error("switch event no irq");
    led_hold_a: assert property ($changed(LED_OUT[0]) |=> $stable(LED_OUT[0]) [*4])
        else $error("LED toggles too fast");
endmodule // blinker_asserts
bind quad_interval_led_blinker blinker_asserts #(.TOGGLE_LIMIT(TOGGLE_LIMIT)) u_chk (
    .CLK_IN, .RST_IN, .CE_IN, .PUSH_SWITCH_INPUT_IN, .ADDR_IN, .WR_IN, .RD_IN, .RDATA_OUT, .LED_OUT,
    .MATCH_FLAG_OUT, .TIMER_SHARED_IRQ_OUT, .SWITCH_EDGE_IRQ_OUT, .IRQ_OUT);
`default_nettype wire

/* File: verification/switch_led_model.sv */
// Push switch and four LEDs on the blinker pins.
// Assumes a pull-up on the switch pin, so a released switch reads high.
`timescale 1ns/1ns
`default_nettype none
`include "blinker_defs.svh"
module switch_led_model (
    input  wire logic               clk_in,    // clock
    input  wire logic [`NUM_CH-1:0] led_in,    // LEDs
    output var  logic               switch_out // pin
);
    int                 cyc = 0;
    int                 stamp [`NUM_CH] = '{default: 0};
    logic [15:0]        gap [`NUM_CH] = '{default: 16'h0000};
    logic [`NUM_CH-1:0] last = 4'h0;
    initial switch_out = 1'h1;
    // Gap holds the cycles between the last two changes of each LED.
    always @(posedge clk_in) begin
        cyc++;
        for (int n = 0; n < `NUM_CH; n++) begin
            if (led_in[n] !== last[n]) begin
                gap[n] = 16'(cyc - stamp[n]);
                stamp[n] = cyc;
            end
        end
        last = led_in;
    end
    // No bounce is modelled: the block counts every fall, so a press is one clean edge.
    task automatic press(input int hold);
        @(posedge clk_in);
        switch_out <= 1'h0;
        repeat (hold) @(posedge clk_in);
        switch_out <= 1'h1;
        repeat (hold) @(posedge clk_in);
    endtask
endmodule // switch_led_model
`default_nettype wire

/* File: verification/quad_interval_led_blinker_test.sv */
// Self-checking bench for the blinker: reads, blink periods per setting, switch and irqs.
// Assumes the design, the switch and LED model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "blinker_defs.svh"
module quad_interval_led_blinker_test;
    localparam logic [`HITS_W-1:0] LIM = 11'h003;
    typedef struct packed {logic [15:0] v; logic [15:0] m;} note_t;
    logic               CLK_IN = 1'h0;
    logic               RST_IN = 1'h1;
    logic               CE_IN = 1'h1;
    logic               WR_IN = 1'h0;
    logic               RD_IN = 1'h0;
    logic               rd_d = 1'h0;
    logic [`ADDR_W-1:0] ADDR_IN = 4'h0;
    logic [`DATA_W-1:0] WDATA_IN = 16'h0000;
    logic [`DATA_W-1:0] RDATA_OUT;
    logic [`NUM_CH-1:0] LED_OUT, MATCH_FLAG_OUT;
    logic               TIMER_SHARED_IRQ_OUT, SWITCH_EDGE_IRQ_OUT, IRQ_OUT, PUSH_SWITCH_INPUT_IN;
    note_t              notes [$];
    int                 bad_count = 0;
    int                 total_checks = 0;
    int                 cycles = 0;
    int                 pulses = 0;
    quad_interval_led_blinker #(.TOGGLE_LIMIT(LIM)) u_dut (.CLK_IN, .RST_IN, .CE_IN,
        .PUSH_SWITCH_INPUT_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .LED_OUT,
        .MATCH_FLAG_OUT, .TIMER_SHARED_IRQ_OUT, .SWITCH_EDGE_IRQ_OUT, .IRQ_OUT);
    switch_led_model u_part (.clk_in(CLK_IN), .led_in(LED_OUT), .switch_out(PUSH_SWITCH_INPUT_IN));
    initial forever #50 CLK_IN = ~CLK_IN;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK_IN);
        WR_IN <= 1'h1;
        ADDR_IN <= a;
        WDATA_IN <= d;
        @(posedge CLK_IN);
        WR_IN <= 1'h0;
    endtask
    // The expected word and the bits worth comparing go into the queue with the read.
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge CLK_IN);
        RD_IN <= 1'h1;
        ADDR_IN <= a;
        notes.push_back('{e, m});
        @(posedge CLK_IN);
        RD_IN <= 1'h0;
    endtask
    always @(posedge CLK_IN) rd_d <= RD_IN;
    always @(negedge CLK_IN) begin
        note_t cur;
        if (SWITCH_EDGE_IRQ_OUT === 1'h1) pulses++;
        if (rd_d) begin
            cur = notes.pop_front();
            check("read data", RDATA_OUT & cur.m, cur.v);
        end
    end
    always @(posedge CLK_IN) begin
        cycles++;
        if (cycles == 25000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        logic [`CMP_W-1:0] cmp [`NUM_CH];
        void'($urandom(22895));
        repeat (2) @(posedge CLK_IN);
        RST_IN <= 1'h0;
        rd(`OFS_MASK, 16'h001F, 16'hFFFF);
        rd(`OFS_SETTING, 16'h0000, 16'hFFFF);
        rd(`OFS_PRESSES, 16'h0000, 16'hFFFF);
        rd(`OFS_LEDS, 16'h0000, 16'hFFFF);
        rd(4'h9, 16'h0000, 16'hFFFF);
        for (int i = 0; i < `NUM_CH; i++) begin
            rd(4'(i), 16'h003F + 16'(i) * 16'h0040, 16'hFFFF);
            cmp[i] = 8'($urandom_range(3, 1));
            wr(4'(i), {8'($urandom), cmp[i]});
            rd(4'(i), {8'h00, cmp[i]}, 16'hFFFF);
        end
        // Each wait covers four of the slowest periods, so the gap is a settled one.
        for (int s = 0; s < 3; s++) begin
            repeat (6200) @(posedge CLK_IN);
            for (int i = 0; i < `NUM_CH; i++) begin
                check("led gap", u_part.gap[i], 16'((cmp[i] + 1) * (1 << ((s + 2 * i) % 8)) * LIM));
            end
            u_part.press(int'($urandom_range(8, 3)));
        end
        rd(`OFS_STATUS, 16'h001F, 16'h001F);
        wr(`OFS_STATUS, 16'h0010);
        rd(`OFS_STATUS, 16'h000F, 16'h001F);
        wr(`OFS_MASK, 16'h0010);
        @(negedge CLK_IN);
        check("timer irq masked", {15'h0000, TIMER_SHARED_IRQ_OUT}, 16'h0000);
        check("any irq masked", {15'h0000, IRQ_OUT}, 16'h0000);
        check("match flags", {12'h000, MATCH_FLAG_OUT}, 16'h000F);
        wr(`OFS_MASK, 16'h001F);
        @(negedge CLK_IN);
        check("timer irq open", {15'h0000, TIMER_SHARED_IRQ_OUT}, 16'h0001);
        check("any irq open", {15'h0000, IRQ_OUT}, 16'h0001);
        for (int k = 4; k <= 9; k++) begin
            u_part.press(int'($urandom_range(8, 3)));
            rd(`OFS_SETTING, 16'(k % 8), 16'hFFFF);
            rd(`OFS_PRESSES, 16'(k), 16'hFFFF);
        end
        // A frozen block must miss a whole press: no pulse, no count, no new setting.
        @(posedge CLK_IN);
        CE_IN <= 1'h0;
        u_part.press(3);
        CE_IN <= 1'h1;
        rd(`OFS_PRESSES, 16'h0009, 16'hFFFF);
        rd(`OFS_SETTING, 16'h0001, 16'hFFFF);
        check("edge pulses", 16'(pulses), 16'h0009);
        repeat (2) @(posedge CLK_IN);
        RST_IN <= 1'h1;
        repeat (2) @(posedge CLK_IN);
        RST_IN <= 1'h0;
        rd(`OFS_PRESSES, 16'h0000, 16'hFFFF);
        rd(`OFS_SETTING, 16'h0000, 16'hFFFF);
        repeat (2) @(posedge CLK_IN);
        report_and_stop();
    end
endmodule // quad_interval_led_blinker_test
`default_nettype wire
